// ==== rtl/hvp_map.svh ====
// register offsets, field positions, reset values and scaler constants
`ifndef HVP_MAP_SVH
`define HVP_MAP_SVH
`define HVP_OFS_RATIO 8'hA0
`define HVP_OFS_ACCUM 8'hA1
`define HVP_OFS_PFWG 8'hA2
`define HVP_OFS_BANK_B 8'h30
`define HVP_NREG_LAST 8'h02
`define HVP_RST_RATIO 8'h01
`define HVP_RST_ACCUM 8'h00
`define HVP_RST_PFWG 8'h00
`define HVP_F_RATIO 5:0
`define HVP_F_LEN 5:0
`define HVP_F_SHIFT 2:0
`define HVP_F_C2 3
`define HVP_F_PFY 5:4
`define HVP_F_PFC 7:6
`define HVP_FS_UNIT 14'h0400
`define HVP_PH_BITS 6
`define HVP_PH_MSB 9
`define HVP_PH_LSB 4
`endif

// ==== rtl/hvp_pkg.sv ====
// types shared by the horizontal prescaler files
package hvp_pkg;
	typedef enum logic [1:0] {PF_BYPASS, PF_121, PF_CIF, PF_12221} hvp_pf_t;
	typedef enum logic {FS_IDLE, FS_RUN} hvp_fs_t;
endpackage

// ==== rtl/hvp_buf2.sv ====
// two-entry valid/ready buffer with registered head entry
`timescale 1ns/10ps
module hvp_buf2 #(
	parameter int W = 18
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic i_clr,
	input wire logic i_valid,
	output logic o_ready,
	input wire logic [W-1:0] i_data,
	output logic o_valid,
	input wire logic i_ready,
	output logic [W-1:0] o_data
);
	logic [1:0] cnt;
	logic [W-1:0] e1;
	logic push;
	logic pop;

	// handshakes come straight from the fill count
	assign o_ready = (cnt != 2'h2);
	assign o_valid = (cnt != 2'h0);
	assign push = i_valid && o_ready;
	assign pop = i_ready && o_valid;

	// fill count
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt <= 2'h0;
		end else if (i_ce) begin
			if (i_clr) begin
				cnt <= 2'h0;
			end else if (push && !pop) begin
				cnt <= 2'(cnt + 2'h1);
			end else if (pop && !push) begin
				cnt <= 2'(cnt - 2'h1);
			end
		end
	end

	// entries: head always sits in o_data
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_data <= '0;
			e1 <= '0;
		end else if (i_ce && !i_clr) begin
			if (push && (!pop || cnt == 2'h1) && cnt != 2'h2 && (cnt == 2'h0 || pop)) begin
				o_data <= i_data;
			end else if (push && !pop) begin
				e1 <= i_data;
			end else if (pop) begin
				o_data <= e1;
				if (push) begin
					e1 <= i_data;
				end
			end
		end
	end
endmodule // hvp_buf2

// ==== rtl/hvp_scaler.sv ====
// horizontal prefilter, integer prescaler and phase fine scaler
// How it works
// - scale ratio is one over prescale times 1024 over fine increment
// - fine scaler interpolates outputs at a 6-bit sub-pixel phase
// - accumulation length field 0..63 averages 1 to 64 pixels
// - weighting bit low gives all ones, high doubles inner pixels
// - dc gain is (weight bit plus one) times length plus (one minus bit)
// - three-bit shift divides the sum by two to its power
// - prefilter plus accumulator form a low-pass up to 64 plus 7 taps
// - selectable prefilters cover scales 1 to 1/2, one tuned for CIF
// - fine scaler spans threefold zoom down to 1024/8191
// - two prescaler banks, one per task, at A0h and D0h
// - prefilter select: bypass, 1-2-1, CIF kernel, 1-2-2-2-1
// - original sample is copied as first and last prescaler pixel of a line; the fine scaler emits only the first unchanged
// - luma and chroma share timing and ratio, filters may differ
`timescale 1ns/10ps
`include "hvp_map.svh"
module hvp_scaler (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic i_swrst_n,
	input wire logic i_task_b,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_we,
	input wire logic i_reg_re,
	output logic [7:0] o_reg_rdata,
	input wire logic [12:0] i_fine_scale_increment,
	input wire logic i_pix_valid,
	output logic o_pix_ready,
	input wire logic [7:0] i_pix_y,
	input wire logic [7:0] i_pix_c,
	input wire logic i_pix_sol,
	input wire logic i_pix_eol,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [7:0] o_out_y,
	output logic [7:0] o_out_c
);
	logic [7:0] cfg [2][3];
	logic [7:0] off;
	logic wr_bank;
	logic wr_hit;
	logic [5:0] int_prescale_ratio;
	logic [5:0] accum_length;
	logic [2:0] gain_renorm_shift;
	logic center_double_weight;
	logic [1:0] pf_sel [2];
	logic b_valid;
	logic [17:0] b_data;
	logic fetch;
	logic [6:0][7:0] tap [2];
	logic [7:0] filt [2];
	logic [3:0] fl_v;
	logic [3:0] fl_s;
	logic [3:0] fl_e;
	logic step;
	logic sol3;
	logic eol3;
	logic start;
	logic sel;
	logic nxt;
	logic [5:0] pc;
	logic slot_act [2];
	logic [5:0] slot_cnt [2];
	logic [15:0] sy [2];
	logic [15:0] sc [2];
	logic [15:0] nsy [2];
	logic [15:0] nsc [2];
	logic dn [2];
	logic ps_valid;
	logic ps_sol;
	logic [7:0] ps_y;
	logic [7:0] ps_c;
	hvp_pkg::hvp_fs_t fs_state;
	logic [13:0] pos;
	logic [7:0] s0y;
	logic [7:0] s1y;
	logic [7:0] s0c;
	logic [7:0] s1c;
	logic need;
	logic fs_take;
	logic emit;
	logic [5:0] ph;

	// prefilter kernels, centre tap is t[3]
	function automatic logic [7:0] pf(input logic [1:0] s, input logic chroma, input logic [6:0][7:0] t);
		int a;
		case (hvp_pkg::hvp_pf_t'(s))
			hvp_pkg::PF_121: a = (int'(t[2]) + 2 * int'(t[3]) + int'(t[4]) + 2) >>> 2;
			hvp_pkg::PF_CIF: begin
				if (chroma) begin
					a = (3 * int'(t[1]) + 8 * int'(t[2]) + 10 * int'(t[3]) + 8 * int'(t[4])
						+ 3 * int'(t[5]) + 16) >>> 5;
				end else begin
					a = (-4 * int'(t[0]) + 4 * int'(t[1]) + 7 * int'(t[2]) + 18 * int'(t[3])
						+ 7 * int'(t[4]) + 4 * int'(t[5]) - 4 * int'(t[6]) + 16) >>> 5;
				end
			end
			hvp_pkg::PF_12221: a = (int'(t[1]) + 2 * int'(t[2]) + 2 * int'(t[3]) + 2 * int'(t[4])
				+ int'(t[5]) + 4) >>> 3;
			default: a = int'(t[3]);
		endcase
		if (a < 0) begin
			a = 0;
		end else if (a > 255) begin
			a = 255;
		end
		return 8'(a);
	endfunction

	// power-of-two renormalisation with saturation
	function automatic logic [7:0] norm(input logic [15:0] v, input logic [2:0] sh);
		logic [15:0] q;
		q = v >> sh;
		return (q > 16'h00FF) ? 8'hFF : q[7:0];
	endfunction

	// linear interpolation between two samples at a 6-bit phase
	function automatic logic [7:0] lerp(input logic [7:0] a, input logic [7:0] b, input logic [5:0] p);
		int d;
		d = int'(b) - int'(a);
		return 8'(int'(a) + ((d * int'(p)) >>> `HVP_PH_BITS));
	endfunction

	// subaddress decode, bank b sits one fixed distance above bank a
	always_comb begin
		wr_bank = (i_reg_addr >= 8'(`HVP_OFS_RATIO + `HVP_OFS_BANK_B));
		off = 8'(i_reg_addr - (wr_bank ? 8'(`HVP_OFS_RATIO + `HVP_OFS_BANK_B) : `HVP_OFS_RATIO));
		wr_hit = (off <= `HVP_NREG_LAST);
	end

	// two register banks, one per task set
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			for (int b = 0; b < 2; b++) begin
				cfg[b][0] <= `HVP_RST_RATIO;
				cfg[b][1] <= `HVP_RST_ACCUM;
				cfg[b][2] <= `HVP_RST_PFWG;
			end
		end else if (i_ce && i_reg_we && wr_hit) begin
			cfg[wr_bank][off[1:0]] <= i_reg_wdata;
		end
	end

	// registered read port, unmapped subaddresses read zero
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_reg_rdata <= 8'h00;
		end else if (i_ce && i_reg_re) begin
			o_reg_rdata <= wr_hit ? cfg[wr_bank][off[1:0]] : 8'h00;
		end
	end

	// active task's settings steer the datapath
	assign int_prescale_ratio = cfg[i_task_b][0][`HVP_F_RATIO];
	assign accum_length = cfg[i_task_b][1][`HVP_F_LEN];
	assign gain_renorm_shift = cfg[i_task_b][2][`HVP_F_SHIFT];
	assign center_double_weight = cfg[i_task_b][2][`HVP_F_C2];
	assign pf_sel[0] = cfg[i_task_b][2][`HVP_F_PFY];
	assign pf_sel[1] = cfg[i_task_b][2][`HVP_F_PFC];

	hvp_buf2 #(.W(18)) u_in_buf (
		.i_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_ce(i_ce),
		.i_clr(!i_swrst_n),
		.i_valid(i_pix_valid),
		.o_ready(o_pix_ready),
		.i_data({i_pix_sol, i_pix_eol, i_pix_y, i_pix_c}),
		.o_valid(b_valid),
		.i_ready(fetch),
		.o_data(b_data)
	);

	// front end advances only when the prescaler output slot is free
	assign fetch = i_ce && i_swrst_n && b_valid && !ps_valid;
	assign step = fetch && fl_v[3];
	assign sol3 = fl_s[3];
	assign eol3 = fl_e[3];

	// seven-tap prefilter delay lines, luma and chroma
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_pf
			assign filt[ch] = pf(pf_sel[ch], (ch == 1), tap[ch]);
			always_ff @(posedge i_ref_clk or posedge i_rst) begin
				if (i_rst) begin
					tap[ch] <= '0;
				end else if (fetch) begin
					tap[ch] <= {tap[ch][5:0], ch == 0 ? b_data[15:8] : b_data[7:0]};
				end
			end
		end
	endgenerate

	// line markers travel with the centre tap
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			fl_v <= 4'h0;
			fl_s <= 4'h0;
			fl_e <= 4'h0;
		end else if (i_ce && !i_swrst_n) begin
			fl_v <= 4'h0;
		end else if (fetch) begin
			fl_v <= {fl_v[2:0], 1'b1};
			fl_s <= {fl_s[2:0], b_data[17]};
			fl_e <= {fl_e[2:0], b_data[16]};
		end
	end

	// a window opens every ratio pixels, shared by both channels
	assign start = step && (sol3 || (pc == 6'h00 && !eol3));
	assign sel = sol3 ? 1'b0 : nxt;

	// pixel-in-period counter and slot toggle
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			pc <= 6'h00;
			nxt <= 1'b0;
		end else if (i_ce && !i_swrst_n) begin
			pc <= 6'h00;
			nxt <= 1'b0;
		end else if (step) begin
			if (sol3) begin
				pc <= (int_prescale_ratio <= 6'h01) ? 6'h00 : 6'h01;
			end else begin
				pc <= (6'(pc + 6'h01) >= int_prescale_ratio) ? 6'h00 : 6'(pc + 6'h01);
			end
			if (start) begin
				nxt <= ~sel;
			end
		end
	end

	// two accumulators so windows up to twice the ratio may overlap
	genvar s;
	generate
		for (s = 0; s < 2; s++) begin : g_acc
			logic st;
			logic [5:0] cur;
			logic hit;
			logic last;
			logic w2;
			assign st = start && (sel == (s == 1));
			assign cur = st ? 6'h00 : slot_cnt[s];
			assign hit = st || slot_act[s];
			assign last = (cur == accum_length);
			assign w2 = center_double_weight && cur != 6'h00 && !last;
			assign nsy[s] = 16'((st ? 16'h0000 : sy[s]) + (w2 ? {7'h00, filt[0], 1'b0} : {8'h00, filt[0]}));
			assign nsc[s] = 16'((st ? 16'h0000 : sc[s]) + (w2 ? {7'h00, filt[1], 1'b0} : {8'h00, filt[1]}));
			assign dn[s] = step && hit && last && !sol3 && !eol3;
			always_ff @(posedge i_ref_clk or posedge i_rst) begin
				if (i_rst) begin
					slot_act[s] <= 1'b0;
					slot_cnt[s] <= 6'h00;
					sy[s] <= 16'h0000;
					sc[s] <= 16'h0000;
				end else if (i_ce && !i_swrst_n) begin
					slot_act[s] <= 1'b0;
				end else if (step) begin
					if (eol3 || (sol3 && !st)) begin
						slot_act[s] <= 1'b0;
					end else if (hit) begin
						slot_act[s] <= !last;
						slot_cnt[s] <= 6'(cur + 6'h01);
						sy[s] <= nsy[s];
						sc[s] <= nsc[s];
					end
				end
			end
		end
	endgenerate

	// prescaler output: line-end copies win over a finishing window
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			ps_valid <= 1'b0;
			ps_sol <= 1'b0;
			ps_y <= 8'h00;
			ps_c <= 8'h00;
		end else if (i_ce && !i_swrst_n) begin
			ps_valid <= 1'b0;
		end else if (step && (sol3 || eol3)) begin
			ps_valid <= 1'b1;
			ps_sol <= sol3;
			ps_y <= tap[0][3];
			ps_c <= tap[1][3];
		end else if (dn[0] || dn[1]) begin
			ps_valid <= 1'b1;
			ps_sol <= 1'b0;
			ps_y <= norm(dn[0] ? nsy[0] : nsy[1], gain_renorm_shift);
			ps_c <= norm(dn[0] ? nsc[0] : nsc[1], gain_renorm_shift);
		end else if (fs_take) begin
			ps_valid <= 1'b0;
		end
	end

	// fine scaler: position in 1/1024 input pixels
	assign need = (pos >= `HVP_FS_UNIT);
	assign ph = pos[`HVP_PH_MSB:`HVP_PH_LSB];
	assign fs_take = i_ce && i_swrst_n && ps_valid && (fs_state == hvp_pkg::FS_IDLE || need);
	assign emit = i_ce && i_swrst_n && fs_state == hvp_pkg::FS_RUN && !need && (!o_out_valid || i_out_ready);

	// sample pair and phase accumulator
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			fs_state <= hvp_pkg::FS_IDLE;
			pos <= 14'h0000;
			s0y <= 8'h00;
			s1y <= 8'h00;
			s0c <= 8'h00;
			s1c <= 8'h00;
		end else if (i_ce && !i_swrst_n) begin
			fs_state <= hvp_pkg::FS_IDLE;
		end else if (fs_take) begin
			if (ps_sol) begin
				s1y <= ps_y;
				s1c <= ps_c;
				pos <= `HVP_FS_UNIT;
				fs_state <= hvp_pkg::FS_RUN;
			end else begin
				case (fs_state)
					hvp_pkg::FS_RUN: begin
						s0y <= s1y;
						s0c <= s1c;
						s1y <= ps_y;
						s1c <= ps_c;
						pos <= 14'(pos - `HVP_FS_UNIT);
					end
					default: fs_state <= hvp_pkg::FS_IDLE;
				endcase
			end
		end else if (emit) begin
			pos <= 14'(pos + {1'b0, i_fine_scale_increment});
		end
	end

	// output register held until the vertical scaler takes it
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_out_valid <= 1'b0;
			o_out_y <= 8'h00;
			o_out_c <= 8'h00;
		end else if (i_ce && !i_swrst_n) begin
			o_out_valid <= 1'b0;
		end else if (emit) begin
			o_out_valid <= 1'b1;
			o_out_y <= lerp(s0y, s1y, ph);
			o_out_c <= lerp(s0c, s1c, ph);
		end else if (i_ce && i_out_ready) begin
			o_out_valid <= 1'b0;
		end
	end

	// checks
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);

	sequence s_wr_ratio;
		i_ce && i_reg_we && i_reg_addr == `HVP_OFS_RATIO;
	endsequence
	sequence s_rd_ratio;
		i_ce && i_reg_re && !i_reg_we && i_reg_addr == `HVP_OFS_RATIO;
	endsequence
	property p_reg_readback;
		s_wr_ratio ##1 s_rd_ratio |=> o_reg_rdata == $past(i_reg_wdata, 2);
	endproperty
	a_reg_readback: assert property (p_reg_readback) else $error("bank a readback mismatch");
	property p_bank_apart;
		i_ce && i_reg_we && i_reg_addr == 8'(`HVP_OFS_RATIO + `HVP_OFS_BANK_B) |=> $stable(cfg[0][0]);
	endproperty
	a_bank_apart: assert property (p_bank_apart) else $error("bank b write touched bank a");
	property p_bypass;
		pf_sel[0] == 2'h0 |-> filt[0] == tap[0][3];
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass prefilter altered luma");
	property p_sol_copy;
		step && sol3 |=> ps_valid && ps_sol && ps_y == $past(tap[0][3]);
	endproperty
	a_sol_copy: assert property (p_sol_copy) else $error("line start not copied");
	property p_unit_window;
		step && !sol3 && !eol3 && pc == 6'h00 && accum_length == 6'h00 && gain_renorm_shift == 3'h0
			|=> ps_valid && ps_y == $past(filt[0]);
	endproperty
	a_unit_window: assert property (p_unit_window) else $error("single pixel window gain wrong");
	property p_ps_from_fetch;
		$rose(ps_valid) |-> $past(step);
	endproperty
	a_ps_from_fetch: assert property (p_ps_from_fetch) else $error("prescaler output without input");
	property p_take_pos;
		i_swrst_n && fs_take && fs_state == hvp_pkg::FS_RUN && !ps_sol |=> pos == 14'($past(pos) - `HVP_FS_UNIT);
	endproperty
	a_take_pos: assert property (p_take_pos) else $error("phase not rewound on take");
	property p_interp_bound;
		emit |=> (o_out_y >= $past(s0y) || o_out_y >= $past(s1y)) && (o_out_y <= $past(s0y) || o_out_y <= $past(s1y));
	endproperty
	a_interp_bound: assert property (p_interp_bound) else $error("interpolated luma out of range");
	property p_out_hold;
		i_swrst_n && o_out_valid && !i_out_ready |=> o_out_valid && $stable(o_out_y);
	endproperty
	a_out_hold: assert property (p_out_hold) else $error("output dropped under stall");
endmodule // hvp_scaler

// ==== dv/hvp_video_end.sv ====
// pixel source and output sink standing at both ends of the scaler stream
`timescale 1ns/10ps
module hvp_video_end (
	input wire logic i_ref_clk,
	input wire logic i_pix_ready,
	input wire logic i_out_valid,
	input wire logic [7:0] i_out_y,
	input wire logic [7:0] i_out_c,
	output logic o_pix_valid,
	output logic [7:0] o_pix_y,
	output logic [7:0] o_pix_c,
	output logic o_pix_sol,
	output logic o_pix_eol,
	output logic o_out_ready
);
	int stall_mode = 0;
	int cyc = 0;
	int open_at = 0;
	logic saw_full = 1'b0;
	logic [7:0] got_y[$];
	logic [7:0] got_c[$];

	// idle source, sink ready
	initial begin
		o_pix_valid = 1'b0;
		o_pix_y = 8'h00;
		o_pix_c = 8'h00;
		o_pix_sol = 1'b0;
		o_pix_eol = 1'b0;
		o_out_ready = 1'b1;
	end

	// sink ready pattern: always, every other cycle, or held off until open_at
	always @(negedge i_ref_clk) begin
		cyc <= cyc + 1;
		o_out_ready <= (stall_mode == 0) || (stall_mode == 1 && cyc[0]) || (stall_mode == 2 && cyc > open_at);
	end

	// collect every output pair taken by the sink
	always @(posedge i_ref_clk) begin
		if (i_out_valid === 1'b1 && o_out_ready === 1'b1) begin
			got_y.push_back(i_out_y);
			got_c.push_back(i_out_c);
		end
	end

	// offer one pixel at a falling edge and hold it until a rising edge takes it
	task automatic send_pix(input logic [7:0] y, input logic [7:0] c, input logic sol, input logic eol);
		logic rdy;
		o_pix_valid = 1'b1;
		o_pix_y = y;
		o_pix_c = c;
		o_pix_sol = sol;
		o_pix_eol = eol;
		do begin
			rdy = i_pix_ready;
			if (rdy !== 1'b1) saw_full = 1'b1;
			@(negedge i_ref_clk);
		end while (rdy !== 1'b1);
	endtask

	// one framed line of constant pixels, start and end marked
	task automatic send_line(input int n, input logic [7:0] y, input logic [7:0] c);
		for (int i = 0; i < n; i++) send_pix(y, c, i == 0, i == n - 1);
	endtask

	// release the stream; data lines show no stale value
	task automatic rest();
		o_pix_valid = 1'b0;
		o_pix_y = ~o_pix_y;
		o_pix_c = ~o_pix_c;
		o_pix_sol = 1'b0;
		o_pix_eol = 1'b0;
	endtask
endmodule // hvp_video_end

// ==== dv/hvp_scaler_bench.sv ====
// self-checking bench for the horizontal prescaler and fine scaler
`timescale 1ns/10ps
module hvp_scaler_bench;
	typedef struct {
		logic tb;
		logic [7:0] ratio;
		logic [7:0] len;
		logic [7:0] pfwg;
		logic [12:0] inc;
		int stall;
		logic [7:0] ey;
		logic [7:0] ec;
	} hvp_case_t;
	logic clk, rst, ce, swrst_n, task_b, we, re;
	logic [7:0] addr, wdata, rdata, oy, oc, py, pc, d;
	logic [12:0] inc;
	logic pv, pr, psol, peol, ov, ordy;
	int err_count = 0;
	int checked = 0;
	logic [7:0] ra[6] = '{8'hA0, 8'hA1, 8'hA2, 8'hD0, 8'hD1, 8'hD2};
	logic [7:0] rv[6] = '{8'h01, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
	// bank, ratio, length, filter/weight/shift, increment, stall, expected mid luma and chroma (pixel 28h/18h)
	hvp_case_t cases[9] = '{
		'{1'b0, 8'h01, 8'h00, 8'h00, 13'h0400, 0, 8'h28, 8'h18},
		'{1'b0, 8'h02, 8'h01, 8'h51, 13'h0400, 1, 8'h28, 8'h18},
		'{1'b0, 8'h02, 8'h02, 8'hAA, 13'h0400, 0, 8'h28, 8'h18},
		'{1'b0, 8'h03, 8'h04, 8'hFB, 13'h0800, 0, 8'h28, 8'h18},
		'{1'b0, 8'h02, 8'h02, 8'h00, 13'h0400, 2, 8'h78, 8'h48},
		'{1'b0, 8'h02, 8'h03, 8'h09, 13'h0400, 0, 8'h78, 8'h48},
		'{1'b1, 8'h01, 8'h01, 8'h00, 13'h0400, 0, 8'h50, 8'h30},
		'{1'b1, 8'h04, 8'h06, 8'h00, 13'h0400, 0, 8'hFF, 8'hA8},
		'{1'b0, 8'h01, 8'h00, 8'h00, 13'h012C, 0, 8'h28, 8'h18}
	};

	hvp_scaler DUT (.i_ref_clk(clk), .i_rst(rst), .i_ce(ce), .i_swrst_n(swrst_n), .i_task_b(task_b),
		.i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_we(we), .i_reg_re(re), .o_reg_rdata(rdata),
		.i_fine_scale_increment(inc), .i_pix_valid(pv), .o_pix_ready(pr), .i_pix_y(py), .i_pix_c(pc),
		.i_pix_sol(psol), .i_pix_eol(peol), .o_out_valid(ov), .i_out_ready(ordy), .o_out_y(oy), .o_out_c(oc));

	hvp_video_end far (.i_ref_clk(clk), .i_pix_ready(pr), .i_out_valid(ov), .i_out_y(oy), .i_out_c(oc),
		.o_pix_valid(pv), .o_pix_y(py), .o_pix_c(pc), .o_pix_sol(psol), .o_pix_eol(peol), .o_out_ready(ordy));

	// 40 MHz pixel clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// count and report one comparison
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	// register write, one strobe cycle plus a quiet cycle
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
		addr = a;
		wdata = v;
		we = 1'b1;
		@(negedge clk);
		we = 1'b0;
		@(negedge clk);
	endtask

	// register read, data taken at the second falling edge after the read edge
	task automatic reg_rd(input logic [7:0] a, output logic [7:0] v);
		addr = a;
		re = 1'b1;
		@(negedge clk);
		re = 1'b0;
		@(negedge clk);
		v = rdata;
	endtask

	// wait until the output has been quiet for a while, bounded
	task automatic drain();
		int quiet;
		quiet = 0;
		for (int i = 0; i < 3000 && quiet < 40; i++) begin
			@(negedge clk);
			quiet = (ov === 1'b0) ? quiet + 1 : 0;
		end
	endtask

	// program one bank, flush, stream two constant lines and judge the output
	task automatic run_case(input hvp_case_t k);
		logic [7:0] base;
		int n, want, tol;
		base = k.tb ? 8'hD0 : 8'hA0;
		reg_wr(base, k.ratio);
		reg_wr(base + 8'h01, k.len);
		reg_wr(base + 8'h02, k.pfwg);
		task_b = k.tb;
		inc = k.inc;
		swrst_n = 1'b0;
		@(negedge clk);
		swrst_n = 1'b1;
		@(negedge clk);
		check("output valid after flush", 8'h00, {7'h00, ov});
		far.got_y.delete();
		far.got_c.delete();
		far.saw_full = 1'b0;
		far.stall_mode = k.stall;
		far.open_at = far.cyc + 60;
		far.send_line(32, 8'h28, 8'h18);
		far.send_line(32, 8'h28, 8'h18);
		far.rest();
		drain();
		n = far.got_y.size();
		want = 65536 / (int'(k.ratio) * int'(k.inc));
		tol = want / 8 + 6;
		check("output count in range", 8'h01, {7'h00, n >= want - tol && n <= want + tol});
		check("mid luma", k.ey, far.got_y[n / 4]);
		check("mid chroma", k.ec, far.got_c[n / 4]);
		check("first luma copied raw", 8'h28, far.got_y[0]);
		if (k.stall == 2) check("input stalled by full buffer", 8'h01, {7'h00, far.saw_full});
		if (k.inc == 13'h012C) check("zoom gives more outputs", 8'h01, {7'h00, n > 150});
	endtask

	// watchdog far beyond the expected run length
	initial begin
		#(25 * 60000);
		err_count++;
		$display("watchdog expired");
		wrap_up();
	end

	// main sequence: reset, registers, then the datapath cases
	initial begin
		rst = 1'b1;
		ce = 1'b1;
		swrst_n = 1'b1;
		task_b = 1'b0;
		we = 1'b0;
		re = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
		inc = 13'h0400;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		check("input ready after reset", 8'h01, {7'h00, pr});
		for (int i = 0; i < 6; i++) begin
			reg_rd(ra[i], d);
			check("register reset value", rv[i], d);
		end
		for (int i = 0; i < 6; i++) reg_wr(ra[i], 8'h11 + 8'(i * 17));
		for (int i = 0; i < 6; i++) begin
			reg_rd(ra[i], d);
			check("register readback", 8'h11 + 8'(i * 17), d);
		end
		reg_wr(8'hA3, 8'h5A);
		reg_rd(8'hA3, d);
		check("unmapped read", 8'h00, d);
		reg_rd(8'h00, d);
		check("unmapped low read", 8'h00, d);
		// write then read in the very next cycle
		addr = 8'hA0;
		wdata = 8'h2C;
		we = 1'b1;
		@(negedge clk);
		we = 1'b0;
		re = 1'b1;
		@(negedge clk);
		re = 1'b0;
		@(negedge clk);
		check("back to back readback", 8'h2C, rdata);
		reg_wr(8'hA0, 8'h01);
		reg_wr(8'hA1, 8'h00);
		reg_wr(8'hA2, 8'h00);
		// a write while the clock enable is low must not land
		ce = 1'b0;
		reg_wr(8'hA0, 8'h3F);
		ce = 1'b1;
		reg_rd(8'hA0, d);
		check("write ignored while frozen", 8'h01, d);
		foreach (cases[i]) run_case(cases[i]);
		wrap_up();
	end

	// single place where the run ends
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
endmodule // hvp_scaler_bench
